// >>> hdl/power_down_mode_control.sv
// Power-down mode controller with APB register slave
//
// Overview of operation
// - A sleep request with standby select and deep sleep clear enters sleep with peripherals running.
// - A sleep request with standby select set enters standby, halting clocks and self-refresh.
// - A sleep request with standby select clear and deep sleep set enters deep sleep, DMA off.
// - A low standby request pin forces hardware standby, left only by power-on reset.
// - Status pins show HH in reset, HL in sleep, LH in standby and LL in normal operation.
// - A set module-stop bit gates that peripheral's clock; clearing it or reset restores it.
// - The 8-bit standby control register resets to zero on power-on or watchdog reset.
// - With the pin high-impedance bit set, peripheral pins float during standby.
// - With the pull-up-off bit clear, peripheral pins in input or float state are pulled up outside hardware standby.
// - The real-time clock keeps counting in every standby mode while its start bit is set.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module power_down_mode_control
  import pdm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Core and system events
  input  wire logic        sleep_req,
  input  wire logic        irq_accept,
  input  wire logic        wdt_overflow,
  input  wire logic        rtc_start,
  input  wire logic        hw_standby_req_n,
  // Processor state pins
  output logic             proc_state_hi,
  output logic             proc_state_hi_oe,
  output logic             proc_state_lo,
  output logic             proc_state_lo_oe,
  // Power and clock controls
  output logic             cpu_halt,
  output logic             clock_generator_stop,
  output logic             periph_halt,
  output logic             mem_self_refresh,
  output logic             pins_hiz,
  output logic             periph_pin_hiz_en,
  output logic             periph_pullup_en,
  output logic             dma_clk_en,
  output logic             serial2_clk_en,
  output logic             timer_clk_en,
  output logic             rtc_clk_en,
  output logic             serial1_clk_en,
  output logic             store_queue_clk_en,
  output logic             break_clk_en,
  output logic             rtc_count_en,
  output logic [31:0]      clock_stop_vec
);

  typedef struct packed {
    mode_t       mode;
    logic [7:0]  standby_control;
    logic [7:0]  standby_control_two;
    logic [31:0] clock_stop_set;
    logic [31:0] rdata;
  } pdm_state_t;

  pdm_state_t st_r;
  pdm_state_t st_nxt;
  logic       hw_req_n_sync;
  logic       setup_ph;
  logic       access_ph;
  logic       wr_en;
  logic       hit_sc;
  logic       hit_sc2;
  logic       hit_cs;
  logic       hit_cr;
  logic       mapped;
  logic       standby_select_sel;
  logic       deep_sel;
  logic       in_sleep_any;

  // Standby request pin crossing
  sync2 #(
    .RESET_VAL (1'b1)
  ) u_hw_req_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (hw_standby_req_n),
    .sync_out (hw_req_n_sync)
  );

  // APB decode
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign hit_sc    = (paddr == STANDBY_CONTROL_ADDR);
  assign hit_sc2   = (paddr == STANDBY_CONTROL_TWO_ADDR);
  assign hit_cs    = (paddr == CLOCK_STOP_SET_ADDR);
  assign hit_cr    = (paddr == CLOCK_STOP_RELEASE_ADDR);
  assign mapped    = hit_sc | hit_sc2 | hit_cs | hit_cr;
  assign wr_en     = access_ph & pwrite & mapped;
  assign pready    = access_ph;
  assign pslverr   = access_ph & ~mapped;
  assign prdata    = st_r.rdata;

  // Mode selection bits
  assign standby_select_sel     = st_r.standby_control[STANDBY_SELECT_BIT];
  assign deep_sel     = st_r.standby_control_two[DEEP_SLEEP_SELECT_BIT];
  assign in_sleep_any = (st_r.mode == st_sleep) | (st_r.mode == st_deep_sleep)
                      | (st_r.mode == st_standby);

  // Next state: mode sequencer and register writes
  always_comb begin
    st_nxt = st_r;
    // Read data captured in the setup phase
    if (setup_ph && !pwrite) begin
      st_nxt.rdata = 32'h00000000;
      if (hit_sc) begin
        st_nxt.rdata = {24'h000000, st_r.standby_control};
      end else if (hit_sc2) begin
        st_nxt.rdata = {24'h000000, st_r.standby_control_two};
      end else if (hit_cs) begin
        st_nxt.rdata = st_r.clock_stop_set;
      end
    end
    // Register writes at the access edge
    if (wr_en && pstrb[0] && hit_sc) begin
      st_nxt.standby_control = pwdata[7:0];
    end
    if (wr_en && pstrb[0] && hit_sc2) begin
      st_nxt.standby_control_two = pwdata[7:0] & STANDBY_CONTROL_TWO_MASK;
    end
    if (wr_en && hit_cs) begin
      for (int i = 0; i < 4; i++) begin
        if (pstrb[i]) begin
          st_nxt.clock_stop_set[i*8 +: 8] = st_r.clock_stop_set[i*8 +: 8] | pwdata[i*8 +: 8];
        end
      end
    end
    if (wr_en && hit_cr) begin
      for (int i = 0; i < 4; i++) begin
        if (pstrb[i]) begin
          st_nxt.clock_stop_set[i*8 +: 8] = st_r.clock_stop_set[i*8 +: 8] & ~pwdata[i*8 +: 8];
        end
      end
    end
    // Mode sequencing
    unique case (st_r.mode)
      st_reset: begin
        st_nxt.mode = st_normal;
      end
      st_normal: begin
        if (sleep_req) begin
          if (standby_select_sel) begin
            st_nxt.mode = st_standby;
          end else if (deep_sel) begin
            st_nxt.mode = st_deep_sleep;
          end else begin
            st_nxt.mode = st_sleep;
          end
        end
      end
      st_sleep, st_deep_sleep, st_standby: begin
        if (irq_accept) begin
          st_nxt.mode = st_normal;
        end
      end
      st_hw_standby: begin
        st_nxt.mode = st_hw_standby;
      end
      default: begin
        st_nxt.mode = st_reset;
      end
    endcase
    // Watchdog reset clears registers and leaves soft modes
    if (wdt_overflow && st_r.mode != st_hw_standby) begin
      st_nxt.mode                = st_reset;
      st_nxt.standby_control     = STANDBY_CONTROL_RST;
      st_nxt.standby_control_two = STANDBY_CONTROL_TWO_RST;
      st_nxt.clock_stop_set      = CLOCK_STOP_SET_RST;
    end
    // Standby request pin overrides all
    if (!hw_req_n_sync) begin
      st_nxt.mode = st_hw_standby;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.mode                <= st_reset;
      st_r.standby_control     <= STANDBY_CONTROL_RST;
      st_r.standby_control_two <= STANDBY_CONTROL_TWO_RST;
      st_r.clock_stop_set      <= CLOCK_STOP_SET_RST;
      st_r.rdata               <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Processor state pins
  always_comb begin
    proc_state_hi    = 1'b0;
    proc_state_lo    = 1'b0;
    proc_state_hi_oe = 1'b1;
    proc_state_lo_oe = 1'b1;
    unique case (st_r.mode)
      st_reset: begin
        proc_state_hi = 1'b1;
        proc_state_lo = 1'b1;
      end
      st_normal: begin
        proc_state_hi = 1'b0;
        proc_state_lo = 1'b0;
      end
      st_sleep, st_deep_sleep: begin
        proc_state_hi = 1'b1;
        proc_state_lo = 1'b0;
      end
      st_standby: begin
        proc_state_hi = 1'b0;
        proc_state_lo = 1'b1;
      end
      st_hw_standby: begin
        proc_state_hi    = 1'b0;
        proc_state_lo    = 1'b1;
        proc_state_hi_oe = st_r.standby_control_two[STATUS_PIN_DRIVE_BIT];
        proc_state_lo_oe = st_r.standby_control_two[STATUS_PIN_DRIVE_BIT];
      end
      default: begin
        proc_state_hi = 1'b1;
        proc_state_lo = 1'b1;
      end
    endcase
  end

  // Core, clock generator and memory controls
  assign cpu_halt             = in_sleep_any | (st_r.mode == st_hw_standby);
  assign clock_generator_stop = (st_r.mode == st_standby) | (st_r.mode == st_hw_standby);
  assign periph_halt          = clock_generator_stop;
  assign mem_self_refresh     = (st_r.mode == st_deep_sleep) | (st_r.mode == st_standby);
  assign pins_hiz             = (st_r.mode == st_hw_standby);

  // Peripheral pin float and pull-up controls
  assign periph_pin_hiz_en = st_r.standby_control[PERIPH_PIN_HIZ_BIT]
                           & (st_r.mode == st_standby);
  assign periph_pullup_en  = ~st_r.standby_control[PERIPH_PIN_PULLUP_OFF_BIT]
                           & ~pins_hiz;

  // Module clock gating
  assign dma_clk_en = ~st_r.standby_control[DMA_CLOCK_STOP_BIT] & ~periph_halt
                    & (st_r.mode != st_deep_sleep);
  assign serial2_clk_en     = ~st_r.standby_control[SERIAL2_CLOCK_STOP_BIT] & ~periph_halt;
  assign timer_clk_en       = ~st_r.standby_control[TIMER_CLOCK_STOP_BIT] & ~periph_halt;
  assign rtc_clk_en         = ~st_r.standby_control[RTC_CLOCK_STOP_BIT] & ~periph_halt;
  assign serial1_clk_en     = ~st_r.standby_control[SERIAL1_CLOCK_STOP_BIT] & ~periph_halt;
  assign store_queue_clk_en = ~st_r.standby_control_two[STORE_QUEUE_STOP_BIT] & ~periph_halt;
  assign break_clk_en       = ~st_r.standby_control_two[BREAK_CLOCK_STOP_BIT] & ~periph_halt;
  assign clock_stop_vec     = st_r.clock_stop_set;

  // Real-time clock counting stays on its own start bit
  assign rtc_count_en = rtc_start;

  // Sleep entry
  sleep_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.mode == st_normal) && sleep_req && !standby_select_sel && !deep_sel
      && !wdt_overflow && hw_req_n_sync |=> (st_r.mode == st_sleep) && cpu_halt
      && !clock_generator_stop && !mem_self_refresh)
    else $error("sleep entry wrong");

  // Standby entry
  standby_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.mode == st_normal) && sleep_req && standby_select_sel && !wdt_overflow && hw_req_n_sync
      |=> clock_generator_stop && mem_self_refresh && !proc_state_hi && proc_state_lo)
    else $error("standby entry wrong");

  // Deep sleep entry
  deep_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.mode == st_normal) && sleep_req && !standby_select_sel && deep_sel
      && !wdt_overflow && hw_req_n_sync |=> !dma_clk_en && mem_self_refresh && cpu_halt)
    else $error("deep sleep entry wrong");

  // Wake on interrupt
  irq_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    in_sleep_any && irq_accept && !wdt_overflow && hw_req_n_sync
      |=> (st_r.mode == st_normal) && !cpu_halt && !proc_state_hi && !proc_state_lo)
    else $error("interrupt did not wake core");

  // Hardware standby entry and hold
  hw_standby_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !hw_standby_req_n ##1 !hw_standby_req_n ##1 !hw_standby_req_n
      |=> pins_hiz ##1 pins_hiz [*3])
    else $error("hardware standby not held");

  // Status pins in reset after watchdog
  reset_status_a: assert property (@(posedge pclk) disable iff (!presetn)
    wdt_overflow && hw_req_n_sync && (st_r.mode != st_hw_standby)
      |=> proc_state_hi && proc_state_lo ##1 (st_r.mode == st_normal) || !hw_req_n_sync)
    else $error("status pins not HH in reset");

  // DMA clock stop bit
  dma_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.standby_control[DMA_CLOCK_STOP_BIT] |-> !dma_clk_en)
    else $error("dma clock not gated");

  // Watchdog clears standby control
  wdt_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wdt_overflow && (st_r.mode != st_hw_standby) |=> (st_r.standby_control == STANDBY_CONTROL_RST))
    else $error("standby control not cleared");

  // Peripheral pin float in standby
  periph_hiz_a: assert property (@(posedge pclk) disable iff (!presetn)
    periph_pin_hiz_en |-> (st_r.mode == st_standby)
      && st_r.standby_control[PERIPH_PIN_HIZ_BIT])
    else $error("peripheral pins floated outside standby");

  // Pull-up control
  pullup_ctl_a: assert property (@(posedge pclk) disable iff (!presetn)
    !st_r.standby_control[PERIPH_PIN_PULLUP_OFF_BIT] && !pins_hiz |-> periph_pullup_en)
    else $error("pull-ups not enabled");

  // Real-time clock counting
  rtc_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    rtc_start && (clock_generator_stop || pins_hiz) |-> rtc_count_en)
    else $error("rtc stopped in standby");

  // Status pins in normal operation
  normal_status_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.mode == st_normal) |-> !proc_state_hi && !proc_state_lo
      && proc_state_hi_oe && proc_state_lo_oe)
    else $error("status pins not LL in normal operation");

  // DMA clock back once its stop bit clears
  dma_restore_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(st_r.standby_control[DMA_CLOCK_STOP_BIT]) && (st_r.mode == st_normal)
      |-> dma_clk_en)
    else $error("dma clock not restored");

  // Hardware standby is never left while running
  hw_stay_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.mode == st_hw_standby) |=> (st_r.mode == st_hw_standby) && pins_hiz)
    else $error("hardware standby left without reset");

  // Peripheral pins float whenever standby asks for it
  hiz_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.mode == st_standby) && st_r.standby_control[PERIPH_PIN_HIZ_BIT]
      |-> periph_pin_hiz_en)
    else $error("peripheral pins not floated in standby");

  // Status pin drive in hardware standby
  status_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.mode == st_hw_standby) |-> !proc_state_hi && proc_state_lo
      && (proc_state_hi_oe == st_r.standby_control_two[STATUS_PIN_DRIVE_BIT])
      && (proc_state_lo_oe == st_r.standby_control_two[STATUS_PIN_DRIVE_BIT]))
    else $error("status pin drive wrong in hardware standby");

endmodule

// >>> hdl/pdm_pkg.sv
// Constants, register map and mode encoding of the power-down controller
package pdm_pkg;

  // Register byte addresses
  localparam logic [31:0] STANDBY_CONTROL_ADDR     = 32'hffc00004;
  localparam logic [31:0] STANDBY_CONTROL_TWO_ADDR = 32'hffc00010;
  localparam logic [31:0] CLOCK_STOP_SET_ADDR      = 32'hfe0a0000;
  localparam logic [31:0] CLOCK_STOP_RELEASE_ADDR  = 32'hfe0a0008;

  // Reset values
  localparam logic [7:0]  STANDBY_CONTROL_RST      = 8'h00;
  localparam logic [7:0]  STANDBY_CONTROL_TWO_RST  = 8'h00;
  localparam logic [31:0] CLOCK_STOP_SET_RST       = 32'h00000000;

  // Standby control field positions
  localparam int STANDBY_SELECT_BIT        = 7;
  localparam int PERIPH_PIN_HIZ_BIT        = 6;
  localparam int PERIPH_PIN_PULLUP_OFF_BIT = 5;
  localparam int DMA_CLOCK_STOP_BIT        = 4;
  localparam int SERIAL2_CLOCK_STOP_BIT    = 3;
  localparam int TIMER_CLOCK_STOP_BIT      = 2;
  localparam int RTC_CLOCK_STOP_BIT        = 1;
  localparam int SERIAL1_CLOCK_STOP_BIT    = 0;

  // Standby control two field positions
  localparam int DEEP_SLEEP_SELECT_BIT     = 7;
  localparam int STATUS_PIN_DRIVE_BIT      = 6;
  localparam int STORE_QUEUE_STOP_BIT      = 1;
  localparam int BREAK_CLOCK_STOP_BIT      = 0;
  localparam logic [7:0] STANDBY_CONTROL_TWO_MASK = 8'hc3;

  // Processor operating modes
  typedef enum logic [2:0] {
    st_reset,
    st_normal,
    st_sleep,
    st_deep_sleep,
    st_standby,
    st_hw_standby
  } mode_t;

endpackage

// >>> hdl/sync2.sv
// Two-flop synchroniser for an asynchronous level input
`timescale 1ns/1ps
module sync2
  import pdm_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      sync_out
);

  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // Shift the pin through two stages
  always_comb begin
    st_nxt        = st_r;
    st_nxt.stage1 = async_in;
    st_nxt.stage2 = st_r.stage1;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= {RESET_VAL, RESET_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stage2;

endmodule

// >>> dv/core_side_model.sv
// Core-side partner: sleep and interrupt-accept pulses after a lag
`timescale 1ns/1ps
module core_side_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       sleep_cmd,
  input  wire logic       wake_cmd,
  input  wire logic [1:0] lag,
  output logic            sleep_req,
  output logic            irq_accept
);
  logic [2:0] cnt_r;
  logic       kind_r;
  // Count the lag down, then one single-cycle pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 3'h0;
      kind_r <= 1'b0;
      sleep_req <= 1'b0;
      irq_accept <= 1'b0;
    end else begin
      sleep_req <= 1'b0;
      irq_accept <= 1'b0;
      if (sleep_cmd || wake_cmd) begin
        cnt_r <= {1'b0, lag} + 3'h1;
        kind_r <= wake_cmd;
      end else if (cnt_r == 3'h1) begin
        sleep_req <= !kind_r;
        irq_accept <= kind_r;
        cnt_r <= 3'h0;
      end else if (cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
      end
    end
  end
endmodule

// >>> dv/tb_top.sv
// Self-checking testbench of the power-down mode controller
`timescale 1ns/1ps
module tb_top;
  import pdm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, probe;
  logic [31:0] paddr, pwdata, prdata, r, q, s;
  logic [3:0]  pstrb;
  logic [1:0]  lag;
  logic        sleep_cmd, wake_cmd, sleep_req, irq_accept, wdt_overflow, rtc_start;
  logic        hw_standby_req_n, proc_state_hi, proc_state_hi_oe, proc_state_lo;
  logic        cpu_halt, clock_generator_stop, periph_halt, mem_self_refresh;
  logic        pins_hiz, periph_pin_hiz_en, periph_pullup_en, dma_clk_en;
  logic        timer_clk_en, rtc_count_en, proc_state_lo_oe, serial2_clk_en, rtc_clk_en;
  logic        serial1_clk_en, store_queue_clk_en, break_clk_en, probe_vec;
  logic [31:0] clock_stop_vec;
  logic [18:0] obs;
  logic [32:0] exp_q[$];
  int          n_mismatch, compares, cyc;

  power_down_mode_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
    .irq_accept(irq_accept), .wdt_overflow(wdt_overflow), .rtc_start(rtc_start),
    .hw_standby_req_n(hw_standby_req_n), .proc_state_hi(proc_state_hi),
    .proc_state_hi_oe(proc_state_hi_oe), .proc_state_lo(proc_state_lo),
    .proc_state_lo_oe(proc_state_lo_oe), .cpu_halt(cpu_halt),
    .clock_generator_stop(clock_generator_stop),
    .periph_halt(periph_halt), .mem_self_refresh(mem_self_refresh), .pins_hiz(pins_hiz),
    .periph_pin_hiz_en(periph_pin_hiz_en), .periph_pullup_en(periph_pullup_en),
    .dma_clk_en(dma_clk_en), .serial2_clk_en(serial2_clk_en), .timer_clk_en(timer_clk_en),
    .rtc_clk_en(rtc_clk_en), .serial1_clk_en(serial1_clk_en),
    .store_queue_clk_en(store_queue_clk_en), .break_clk_en(break_clk_en),
    .rtc_count_en(rtc_count_en), .clock_stop_vec(clock_stop_vec));

  core_side_model core (.pclk(pclk), .presetn(presetn), .sleep_cmd(sleep_cmd),
    .wake_cmd(wake_cmd), .lag(lag), .sleep_req(sleep_req), .irq_accept(irq_accept));

  // Observed control outputs, in probe order
  assign obs = {proc_state_hi, proc_state_lo, cpu_halt, clock_generator_stop, periph_halt,
                mem_self_refresh, pins_hiz, periph_pin_hiz_en, periph_pullup_en, dma_clk_en,
                timer_clk_en, proc_state_hi_oe, proc_state_lo_oe, serial2_clk_en, rtc_clk_en,
                serial1_clk_en, store_queue_clk_en, break_clk_en, rtc_count_en};

  // Clock, 100 ns period
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Oldest note against each finished transfer or probe
  always @(posedge pclk) begin
    logic [32:0] got, e;
    if ((psel && penable && pready) || probe || probe_vec) begin
      got = probe_vec ? {1'b0, clock_stop_vec} : {pslverr, pwrite ? 32'h0 : prdata};
      got = probe ? {14'h0, obs} : got;
      e = exp_q.pop_front();
      compares++;
      if (got !== e) begin
        n_mismatch++;
        $display("FAIL t=%0t exp=%h got=%h", $time, e, got);
      end
    end
  end

  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One APB transfer; waits for pready
  task automatic apb(input logic w, input logic [31:0] a, d, input logic [32:0] e);
    @(posedge pclk);
    exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, d, input logic err);
    apb(1'b1, a, d, {err, 32'h0});
  endtask

  task automatic rd(input logic [31:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask

  // Note expected outputs, then sample them one edge later
  task automatic chk(input logic [17:0] e);
    @(posedge pclk);
    exp_q.push_back({14'h0, e, rtc_start});
    probe <= 1'b1;
    @(posedge pclk);
    probe <= 1'b0;
  endtask

  // Note the expected clock-stop vector, then sample it one edge later
  task automatic chk_vec(input logic [31:0] e);
    @(posedge pclk);
    exp_q.push_back({1'b0, e});
    probe_vec <= 1'b1;
    @(posedge pclk);
    probe_vec <= 1'b0;
  endtask

  // Ask the core for sleep or wake, wait for the halt to follow
  task automatic go(input logic wake, input logic want);
    @(posedge pclk);
    lag <= 2'($urandom_range(3));
    sleep_cmd <= !wake;
    wake_cmd <= wake;
    @(posedge pclk);
    sleep_cmd <= 1'b0;
    wake_cmd <= 1'b0;
    while (cpu_halt !== want) begin
      @(posedge pclk);
    end
  endtask

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, probe} = '0;
    {sleep_cmd, wake_cmd, lag, wdt_overflow, rtc_start, probe_vec} = '0;
    hw_standby_req_n = 1'b1;
    r = $urandom(37337);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk(18'h003ff);
    rd(STANDBY_CONTROL_ADDR, 33'h0);
    rd(STANDBY_CONTROL_TWO_ADDR, 33'h0);
    rd(CLOCK_STOP_SET_ADDR, 33'h0);
    $display("test reset done");
    r = $urandom();
    q = $urandom();
    s = $urandom();
    wr(STANDBY_CONTROL_ADDR, {24'h0, r[7:0]}, 1'b0);
    rd(STANDBY_CONTROL_ADDR, {25'h0, r[7:0]});
    wr(STANDBY_CONTROL_TWO_ADDR, {24'h0, r[15:8]}, 1'b0);
    rd(STANDBY_CONTROL_TWO_ADDR, {25'h0, r[15:8] & STANDBY_CONTROL_TWO_MASK});
    wr(CLOCK_STOP_SET_ADDR, r, 1'b0);
    wr(CLOCK_STOP_SET_ADDR, q, 1'b0);
    rd(CLOCK_STOP_SET_ADDR, {1'b0, r | q});
    wr(CLOCK_STOP_RELEASE_ADDR, s, 1'b0);
    chk_vec((r | q) & ~s);
    rd(CLOCK_STOP_SET_ADDR, {1'b0, (r | q) & ~s});
    rd(CLOCK_STOP_RELEASE_ADDR, 33'h0);
    rd(32'hffc00008, {1'b1, 32'h0});
    wr(32'hffc00008, 32'hff, 1'b1);
    wr(STANDBY_CONTROL_ADDR, 32'h0, 1'b0);
    wr(STANDBY_CONTROL_TWO_ADDR, 32'h0, 1'b0);
    $display("test registers done");
    wr(STANDBY_CONTROL_ADDR, 32'h1f, 1'b0);
    wr(STANDBY_CONTROL_TWO_ADDR, 32'h03, 1'b0);
    chk(18'h00260);
    wr(STANDBY_CONTROL_ADDR, 32'h0, 1'b0);
    wr(STANDBY_CONTROL_TWO_ADDR, 32'h0, 1'b0);
    chk(18'h003ff);
    $display("test module stop done");
    rtc_start <= r[16];
    go(1'b0, 1'b1);
    chk(18'h283ff);
    go(1'b1, 1'b0);
    chk(18'h003ff);
    wr(STANDBY_CONTROL_TWO_ADDR, 32'h80, 1'b0);
    go(1'b0, 1'b1);
    chk(18'h292ff);
    go(1'b1, 1'b0);
    $display("test sleep done");
    rtc_start <= 1'b1;
    wr(STANDBY_CONTROL_ADDR, 32'hc0, 1'b0);
    go(1'b0, 1'b1);
    chk(18'h1f660);
    go(1'b1, 1'b0);
    chk(18'h003ff);
    wr(STANDBY_CONTROL_ADDR, 32'ha0, 1'b0);
    go(1'b0, 1'b1);
    chk(18'h1f060);
    go(1'b1, 1'b0);
    $display("test standby done");
    wr(STANDBY_CONTROL_ADDR, 32'h5f, 1'b0);
    @(posedge pclk);
    wdt_overflow <= 1'b1;
    @(posedge pclk);
    wdt_overflow <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(STANDBY_CONTROL_ADDR, 33'h0);
    rd(STANDBY_CONTROL_TWO_ADDR, 33'h0);
    $display("test watchdog done");
    wr(STANDBY_CONTROL_TWO_ADDR, 32'h40, 1'b0);
    hw_standby_req_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(18'h1e860);
    go(1'b1, 1'b1);
    repeat (6) @(posedge pclk);
    chk(18'h1e860);
    presetn <= 1'b0;
    hw_standby_req_n <= 1'b1;
    chk(18'h303ff);
    presetn <= 1'b1;
    chk(18'h003ff);
    hw_standby_req_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(18'h1e800);
    presetn <= 1'b0;
    hw_standby_req_n <= 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(18'h003ff);
    $display("test hardware standby done");
    tally_and_finish();
  end
endmodule
